// ==== design/strength_pkg.sv ====
// Shared constants and types for the signal strength indicator.
// Assumes a single 50 MHz clock; all times are derived from its period.
package strength_pkg;

    // Clock and time base
    localparam int CLK_PERIOD_NS    = 20;
    localparam int STEP_NS          = 208000;     // 0.208 ms per duty step
    localparam int STEP_CYCLES      = STEP_NS / CLK_PERIOD_NS;
    localparam int HOLD_UNIT_NS     = 100000000;  // 100 ms per hold unit
    localparam int HOLD_UNIT_CYCLES = HOLD_UNIT_NS / CLK_PERIOD_NS;

    // Waveform shape: 40 steps, 8.32 ms period, 95 % ceiling
    localparam int          PERIOD_STEPS   = 40;
    localparam logic [5:0]  MAX_DUTY_STEPS = 6'h26;

    // Margin to steps: steps = 2 + 3 * dB / 5
    localparam logic [9:0]  DUTY_OFFSET = 10'h002;
    localparam logic [9:0]  DUTY_MUL    = 10'h003;
    localparam logic [9:0]  DUTY_DIV    = 10'h005;

    // Hold-time setting
    localparam logic [7:0]  CMD_HOLD_CODE = 8'h22;
    localparam logic [7:0]  HOLD_RESET    = 8'h20;
    localparam logic [7:0]  HOLD_FOREVER  = 8'hFF;
    localparam logic [7:0]  HOLD_OFF      = 8'h00;

    typedef struct packed {
        logic       valid;
        logic [7:0] margin;   // dB above sensitivity, 0 at or below it
    } pkt_type;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] code;
        logic [7:0] data;
    } cmd_type;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } rsp_type;

    typedef enum logic [2:0] {
        ST_STARTUP,
        ST_CFG_INPUT,
        ST_WAIT_FIRST,
        ST_HOLD,
        ST_EXPIRED
    } state_type;

endpackage

// ==== design/tick_divider.sv ====
// Restartable divider giving a one-cycle enable every CYCLES clocks.
// Assumes clear comes from logic on the same clock.
`timescale 1ns/1ps
module tick_divider #(
    parameter int CYCLES = 10400
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Control
    input  wire logic clear,
    output logic      tick
);
    localparam int W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);

    logic [W-1:0] count_reg;

    // Clear restarts a full interval, so a new packet gets whole units
    always_ff @(posedge clk) begin
        if (!reset_n || clear) begin
            count_reg <= '0;
        end else if (count_reg == LAST) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_reg + W'(1);
        end
    end

    assign tick = (count_reg == LAST) && !clear;

    AST_TICK_SPACING: assert property (@(posedge clk) disable iff (!reset_n)
        tick |=> !tick) else $error("Divider tick lasted two cycles"); // R03

endmodule

// ==== design/duty_pwm.sv ====
// Forty-step duty generator; one step per step_tick enable.
// Assumes duty never exceeds the 95 % ceiling given by the caller.
`timescale 1ns/1ps
module duty_pwm (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Step enable and duty in steps
    input  wire logic       step_tick,
    input  wire logic [5:0] duty,
    // Waveform
    output logic            level_reg
);
    import strength_pkg::*;

    localparam logic [5:0] LAST_STEP = 6'(PERIOD_STEPS - 1);

    logic [5:0] step_reg;

    // Step position inside the 8.32 ms period
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            step_reg <= 6'h00;
        end else if (step_tick) begin
            step_reg <= (step_reg == LAST_STEP) ? 6'h00 : step_reg + 6'h01; // R03
        end
    end

    // High for the first duty steps of each period
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            level_reg <= 1'b0;
        end else begin
            level_reg <= (step_reg < duty); // R03
        end
    end

    AST_STEP_WRAP: assert property (@(posedge clk) disable iff (!reset_n)
        (step_tick && step_reg == LAST_STEP) |=> step_reg == 6'h00)
        else $error("Step counter did not wrap after step 39"); // R03

    AST_LAST_STEP_LOW: assert property (@(posedge clk) disable iff (!reset_n)
        step_reg == LAST_STEP |=> !level_reg)
        else $error("Output high in the final step"); // R01

endmodule

// ==== design/rssi_pwm_indicator.sv ====
// Strength indicator: drives a duty waveform on a pin shared with a setup input.
// Assumes packet reports and commands come from logic on clk; the pin is asynchronous.
//
// Function
// (R01) Duty never exceeds 95 percent high time.
// (R02) A packet at or below sensitivity gives zero duty.
// (R03) Period is 8.32 ms made of 40 steps of 0.208 ms.
// (R04) Margins of 10, 20 and 30 dB give 20, 35 and 50 percent duty.
// (R05) A non-zero hold drives the last packet's duty for hold times 100 ms.
// (R06) When the hold runs out with no packet the pin stays low until the next packet.
// (R07) After power-up the output is low.
// (R08) A hold of 0xFF never times out and always shows the latest packet.
// (R09) The hold setting is eight bits, 0 to 0xFF, defaulting to 0x20.
// (R10) The hold setting is reached by command code 0x22 and reads back one byte.
// (R11) With a non-zero hold the pin becomes an output held low until the first packet.
// (R12) The pin starts as an input and stays one for the hold duration after power-up.
// (R13) A hold of zero disables the waveform and leaves the pin an input.
// (R14) Every new packet updates the duty and restarts the hold countdown.
`timescale 1ns/1ps
module rssi_pwm_indicator #(
    parameter int STEP_CYCLES_P      = strength_pkg::STEP_CYCLES,
    parameter int HOLD_UNIT_CYCLES_P = strength_pkg::HOLD_UNIT_CYCLES
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    // Packet strength from the receiver
    input  wire strength_pkg::pkt_type pkt,
    // Setting command port and its answer
    input  wire strength_pkg::cmd_type cmd,
    output strength_pkg::rsp_type      rsp,
    // Shared setup / strength pin
    input  wire logic                  setup_strength_pin_in,
    output logic                       setup_strength_pin_out,
    output logic                       setup_strength_pin_oe,
    // Setup level seen while the pin is an input
    output logic                       setup_level
);
    import strength_pkg::*;

    state_type   state_reg;
    state_type   state_next;
    logic [7:0]  strength_hold_time_reg;
    logic [7:0]  elapsed_reg;
    logic [5:0]  duty_reg;
    logic        pin_out_reg;
    logic        pin_oe_reg;
    logic        pin_sync1_reg;
    logic        pin_sync2_reg;
    logic        setup_level_reg;
    rsp_type     rsp_reg;
    logic        restart;
    logic        unit_tick;
    logic        step_tick;
    logic        pwm_level;
    logic        hold_cmd;
    logic        hold_done;
    logic        hold_off;
    logic        driving;

    // Margin in dB to duty steps, clamped to the ceiling
    function automatic logic [5:0] margin_to_steps(input logic [7:0] margin);
        logic [9:0] steps;
        steps = DUTY_OFFSET + (DUTY_MUL * {2'b00, margin}) / DUTY_DIV; // R04
        if (margin == 8'h00) begin
            margin_to_steps = 6'h00; // R02
        end else if (steps > {4'h0, MAX_DUTY_STEPS}) begin
            margin_to_steps = MAX_DUTY_STEPS; // R01
        end else begin
            margin_to_steps = steps[5:0];
        end
    endfunction

    // Output states share one test
    function automatic logic is_drive_state(input state_type s);
        is_drive_state = (s == ST_WAIT_FIRST) || (s == ST_HOLD) || (s == ST_EXPIRED);
    endfunction

    assign hold_cmd  = cmd.valid && (cmd.code == CMD_HOLD_CODE);
    assign hold_off  = (strength_hold_time_reg == HOLD_OFF);
    // At or past the setting, so lowering it mid-count cannot strand the start-up phase
    assign hold_done = (elapsed_reg >= strength_hold_time_reg);
    assign driving   = is_drive_state(state_reg);

    // Time bases: duty steps run freely, hold units restart with the countdown
    tick_divider #(
        .CYCLES (STEP_CYCLES_P)
    ) step_div (
        .clk     (clk),
        .reset_n (reset_n),
        .clear   (1'b0),
        .tick    (step_tick)
    );

    tick_divider #(
        .CYCLES (HOLD_UNIT_CYCLES_P)
    ) unit_div (
        .clk     (clk),
        .reset_n (reset_n),
        .clear   (restart),
        .tick    (unit_tick)
    );

    duty_pwm pwm (
        .clk       (clk),
        .reset_n   (reset_n),
        .step_tick (step_tick),
        .duty      (duty_reg),
        .level_reg (pwm_level)
    );

    // Hold setting; factory value after reset, replaced by command writes
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            strength_hold_time_reg <= HOLD_RESET; // R09
        end else if (hold_cmd && cmd.write) begin
            strength_hold_time_reg <= cmd.data; // R10
        end
    end

    // Read answer: one byte, one cycle after the request
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg.valid <= hold_cmd && !cmd.write; // R10
            rsp_reg.data  <= (hold_cmd && !cmd.write) ? strength_hold_time_reg : 8'h00;
        end
    end

    assign rsp = rsp_reg;

    // Pin direction and hold sequencing
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_STARTUP: begin
                if (hold_off) begin
                    state_next = ST_CFG_INPUT; // R13
                end else if (hold_done) begin
                    state_next = ST_WAIT_FIRST; // R12
                end
            end
            ST_CFG_INPUT: begin
                if (!hold_off) begin
                    state_next = ST_WAIT_FIRST;
                end
            end
            ST_WAIT_FIRST: begin
                if (hold_off) begin
                    state_next = ST_CFG_INPUT; // R13
                end else if (pkt.valid) begin
                    state_next = ST_HOLD; // R11
                end
            end
            ST_HOLD: begin
                if (hold_off) begin
                    state_next = ST_CFG_INPUT; // R13
                end else if (pkt.valid) begin
                    state_next = ST_HOLD; // R14
                end else if (strength_hold_time_reg != HOLD_FOREVER && hold_done) begin // R08
                    state_next = ST_EXPIRED; // R06
                end
            end
            ST_EXPIRED: begin
                if (hold_off) begin
                    state_next = ST_CFG_INPUT; // R13
                end else if (pkt.valid) begin
                    state_next = ST_HOLD; // R06
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg <= ST_STARTUP; // R07
        end else begin
            state_reg <= state_next;
        end
    end

    // A packet in hold or any state change restarts the countdown
    assign restart = (state_next != state_reg) || (pkt.valid && state_reg == ST_HOLD); // R14

    // Elapsed hold units; saturates so an 0xFF hold cannot wrap
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            elapsed_reg <= 8'h00;
        end else if (restart) begin
            elapsed_reg <= 8'h00; // R14
        end else if (unit_tick && elapsed_reg != 8'hFF) begin
            elapsed_reg <= elapsed_reg + 8'h01; // R05
        end
    end

    // Duty follows every packet, even one during the input phase
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            duty_reg <= 6'h00; // R07
        end else if (pkt.valid) begin
            duty_reg <= margin_to_steps(pkt.margin); // R14
        end
    end

    // Pin drive; the waveform shows only while holding a packet
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pin_oe_reg  <= 1'b0; // R12
            pin_out_reg <= 1'b0; // R07
        end else begin
            pin_oe_reg  <= driving; // R11
            pin_out_reg <= (state_reg == ST_HOLD) && pwm_level; // R05
        end
    end

    assign setup_strength_pin_out = pin_out_reg;
    assign setup_strength_pin_oe  = pin_oe_reg;

    // Two-stage synchroniser for the asynchronous pin
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pin_sync1_reg <= 1'b0;
            pin_sync2_reg <= 1'b0;
        end else begin
            pin_sync1_reg <= setup_strength_pin_in;
            pin_sync2_reg <= pin_sync1_reg;
        end
    end

    // Setup level frozen while we drive, since the pin then shows our own output
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            setup_level_reg <= 1'b0;
        end else if (!pin_oe_reg) begin
            setup_level_reg <= pin_sync2_reg;
        end
    end

    assign setup_level = setup_level_reg;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_pkt_margin(logic [7:0] m);
        pkt.valid && pkt.margin == m;
    endsequence

    sequence s_hold_expiring;
        state_reg == ST_HOLD && !pkt.valid && !hold_off &&
        strength_hold_time_reg != HOLD_FOREVER && hold_done;
    endsequence

    sequence s_waiting_first;
        state_reg == ST_WAIT_FIRST ##1 1'b1;
    endsequence

    AST_DUTY_CEILING: assert property (duty_reg <= MAX_DUTY_STEPS)
        else $error("Duty above 95 percent"); // R01

    AST_ZERO_MARGIN: assert property (s_pkt_margin(8'h00) |=> duty_reg == 6'h00)
        else $error("Zero margin gave non-zero duty"); // R02

    AST_MAP_10DB: assert property (s_pkt_margin(8'h0A) |=> duty_reg == 6'h08)
        else $error("10 dB did not give 20 percent"); // R04

    AST_MAP_20DB: assert property (s_pkt_margin(8'h14) |=> duty_reg == 6'h0E)
        else $error("20 dB did not give 35 percent"); // R04

    AST_MAP_30DB: assert property (s_pkt_margin(8'h1E) |=> duty_reg == 6'h14)
        else $error("30 dB did not give 50 percent"); // R04

    AST_EXPIRE_LOW: assert property (s_hold_expiring |=> state_reg == ST_EXPIRED
        ##1 (setup_strength_pin_oe && !setup_strength_pin_out))
        else $error("Hold expiry did not force the pin low"); // R06

    AST_FOREVER_HOLDS: assert property ((state_reg == ST_HOLD &&
        strength_hold_time_reg == HOLD_FOREVER && !(hold_cmd && cmd.write))
        |=> state_reg == ST_HOLD)
        else $error("Hold of 0xFF timed out"); // R08

    AST_RESET_DEFAULT: assert property (!$past(reset_n) |->
        strength_hold_time_reg == HOLD_RESET && !setup_strength_pin_oe)
        else $error("Wrong state after reset"); // R09

    AST_READ_BYTE: assert property ((hold_cmd && !cmd.write) |=>
        rsp.valid && rsp.data == $past(strength_hold_time_reg))
        else $error("Hold read answered wrongly"); // R10

    AST_WAIT_DRIVES_LOW: assert property (s_waiting_first |->
        setup_strength_pin_oe && !setup_strength_pin_out)
        else $error("Pin not driven low before the first packet"); // R11

    AST_STARTUP_INPUT: assert property ((state_reg == ST_STARTUP && !hold_off &&
        !hold_done) |=> !setup_strength_pin_oe)
        else $error("Pin driven during the start-up input phase"); // R12

    AST_ZERO_HOLD_INPUT: assert property ((hold_off && !(hold_cmd && cmd.write))
        |=> state_reg == ST_CFG_INPUT ##1 !setup_strength_pin_oe)
        else $error("Zero hold left the pin driven"); // R13

    AST_PKT_RESTART: assert property ((pkt.valid && driving && !hold_off) |=>
        state_reg == ST_HOLD && elapsed_reg == 8'h00)
        else $error("Packet did not restart the hold"); // R14

    AST_HOLD_TIMING: assert property ((state_reg == ST_HOLD && unit_tick &&
        !restart && elapsed_reg != 8'hFF) |=> elapsed_reg == $past(elapsed_reg) + 8'h01)
        else $error("Hold unit not counted"); // R05

endmodule

// ==== verification/strength_partner.sv ====
// Far-side model: receiver reporting packet margins and indicator sampling the pin.
// Assumes the block's clk; the block takes pkt on rising edges.
`timescale 1ns/1ps
module strength_partner (
    // Clock
    input  wire logic             clk,
    // Packet reports to the block
    output strength_pkg::pkt_type pkt,
    // Shared pin from outside
    input  wire logic             pin_out,
    input  wire logic             pin_oe,
    input  wire logic             cfg_level,
    output logic                  pin_in
);
    import strength_pkg::*;

    // Jumper level shows whenever the block lets go of the pin
    assign pin_in = pin_oe ? pin_out : cfg_level;

    initial begin
        pkt = '0;
    end

    // One-cycle report, launched off the falling edge
    task automatic send_pkt(input logic [7:0] margin);
        @(negedge clk);
        pkt <= '{valid: 1'b1, margin: margin};
        @(negedge clk);
        pkt <= '0;
    endtask

    // Counts driven-high and driven cycles, mid-cycle where outputs settled
    task automatic measure(input int n, output int highs, output int drives);
        highs = 0;
        drives = 0;
        repeat (n) begin
            @(negedge clk);
            highs += int'(pin_oe === 1'b1 && pin_out === 1'b1);
            drives += int'(pin_oe === 1'b1);
        end
    endtask
endmodule

// ==== verification/rssi_pwm_indicator_test.sv ====
// Self-checking bench for the strength indicator with shortened time base.
// Assumes 4 clocks per step and 20 clocks per hold unit.
`timescale 1ns/1ps
module rssi_pwm_indicator_test;
    import strength_pkg::*;

    localparam int STEP = 4;
    localparam int UNIT = 20;
    localparam int PER  = PERIOD_STEPS * STEP;

    logic    clk;
    logic    reset_n;
    pkt_type pkt;
    cmd_type cmd;
    rsp_type rsp;
    logic    pin_in;
    logic    pin_out;
    logic    pin_oe;
    logic    setup_level;
    logic    cfg_level;
    int      n_errors;
    int      n_compared;

    rssi_pwm_indicator #(.STEP_CYCLES_P(STEP), .HOLD_UNIT_CYCLES_P(UNIT)) rssi_pwm_indicator_i (
        .clk(clk), .reset_n(reset_n), .pkt(pkt), .cmd(cmd), .rsp(rsp),
        .setup_strength_pin_in(pin_in), .setup_strength_pin_out(pin_out),
        .setup_strength_pin_oe(pin_oe), .setup_level(setup_level)
    );

    strength_partner strength_partner_i (
        .clk(clk), .pkt(pkt), .pin_out(pin_out), .pin_oe(pin_oe),
        .cfg_level(cfg_level), .pin_in(pin_in)
    );

    // Free-running 50 MHz clock
    always #10 clk = ~clk;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Answer is sampled in the cycle after the taking edge, where it stands
    task automatic command(input logic wr, input logic [7:0] code, input logic [7:0] data,
                           output logic [8:0] answer);
        @(negedge clk);
        cmd = '{valid: 1'b1, write: wr, code: code, data: data};
        @(negedge clk);
        answer = {rsp.valid, rsp.data};
        cmd = '0;
    endtask

    // One full period: exact high count regardless of phase
    task automatic expect_wave(input int highs_exp, input int drives_exp);
        int highs;
        int drives;
        strength_partner_i.measure(PER, highs, drives);
        check(16'(highs), 16'(highs_exp));
        check(16'(drives), 16'(drives_exp));
    endtask

    task automatic test_startup();
        int cnt;
        logic [8:0] ans;
        cnt = 0;
        check(pin_oe, 1'b0);
        check(pin_out, 1'b0);
        command(1'b0, CMD_HOLD_CODE, 8'h00, ans);
        check(ans, {1'b1, HOLD_RESET});
        command(1'b0, 8'h25, 8'h00, ans);
        check(ans, 9'h000);
        cfg_level = 1'b1;
        repeat (4) @(negedge clk);
        check(setup_level, 1'b1);
        // Input phase lasts the default setting in hold units
        while (pin_oe !== 1'b1 && cnt < 2000) begin
            @(negedge clk);
            cnt++;
        end
        check(cnt >= 622 && cnt <= 640, 1'b1);
        expect_wave(0, PER);
    endtask

    task automatic test_duty();
        logic [7:0] margins [5] = '{8'h00, 8'h0A, 8'h14, 8'h1E, 8'hC8};
        int         steps   [5] = '{0, 8, 14, 20, 38};
        for (int i = 0; i < 5; i++) begin
            strength_partner_i.send_pkt(margins[i]);
            repeat (3) @(negedge clk);
            expect_wave(steps[i] * STEP, PER);
        end
    endtask

    // Second packet inside the hold restarts it; then it runs out
    task automatic test_hold();
        logic [8:0] ans;
        command(1'b1, CMD_HOLD_CODE, 8'h14, ans);
        check(ans, 9'h000);
        strength_partner_i.send_pkt(8'h1E);
        repeat (300) @(negedge clk);
        strength_partner_i.send_pkt(8'h1E);
        repeat (200) @(negedge clk);
        expect_wave(20 * STEP, PER);
        repeat (60) @(negedge clk);
        expect_wave(0, PER);
    endtask

    task automatic test_forever();
        logic [8:0] ans;
        command(1'b1, CMD_HOLD_CODE, HOLD_FOREVER, ans);
        // A write under a foreign code must leave the setting alone
        command(1'b1, 8'h25, 8'h00, ans);
        check(ans, 9'h000);
        command(1'b0, CMD_HOLD_CODE, 8'h00, ans);
        check(ans, {1'b1, HOLD_FOREVER});
        strength_partner_i.send_pkt(8'h14);
        repeat (5200) @(negedge clk);
        expect_wave(14 * STEP, PER);
    endtask

    task automatic test_zero();
        logic [8:0] ans;
        command(1'b1, CMD_HOLD_CODE, HOLD_OFF, ans);
        strength_partner_i.send_pkt(8'h1E);
        repeat (3) @(negedge clk);
        expect_wave(0, 0);
        cfg_level = 1'b0;
        repeat (4) @(negedge clk);
        check(setup_level, 1'b0);
        command(1'b1, CMD_HOLD_CODE, HOLD_RESET, ans);
        repeat (3) @(negedge clk);
        check({pin_oe, pin_out}, 2'b10);
        strength_partner_i.send_pkt(8'h0A);
        repeat (3) @(negedge clk);
        expect_wave(8 * STEP, PER);
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Run is about 8200 cycles; cut off well beyond that
    initial begin
        #(20 * 20000);
        n_errors++;
        end_of_test();
    end

    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        cmd = '0;
        cfg_level = 1'b0;
        n_errors = 0;
        n_compared = 0;
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        test_startup();
        test_duty();
        test_hold();
        test_forever();
        test_zero();
        end_of_test();
    end
endmodule
